// File: bmsel_map.svh
// constants for the boot mode select block
`ifndef BMSEL_MAP_SVH
`define BMSEL_MAP_SVH
`define BMSEL_SYNC_STAGES 2
`define BMSEL_MODE_RESET  2'h0
`define BMSEL_CS_IDLE     1'h1
`endif

// File: bmsel_pkg.sv
// types shared by the boot mode select block
package bmsel_pkg;
   typedef enum logic [1:0] {
      bmsel_mode_none_type_e,
      bmsel_mode_host_type_e,
      bmsel_mode_eprom_type_e,
      bmsel_mode_illegal_type_e
   } bmsel_mode_type;

   typedef struct packed {
      logic eprom_boot_strap;
      logic link_boot_strap;
      logic boot_memory_select;
   } bmsel_straps_type;

   typedef struct packed {
      logic boot_memory_select_o;
      logic boot_memory_select_oe;
   } bmsel_pin_type;
endpackage

// File: bmsel_sync.sv
// two-stage synchroniser for a vector of pin inputs
module bmsel_sync #(
   parameter int WIDTH = 3
) (
   // clock and control
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_dout;

   // refuse an empty vector at elaboration, not at run time
   if (WIDTH < 1) begin : g_width_check
      $error("bmsel_sync width must be positive");
   end

   // shift when enabled; first stage read only by second
   always_comb begin
      next_stage1 = clk_en ? din : stage1;
      next_dout   = clk_en ? stage1 : dout;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end
endmodule

// File: bmsel_top.sv
// boot mode strap decode and boot memory select pin control
// Function
// RULE_01: eprom boot strap high selects byte-wide eprom boot, other straps ignored.
// RULE_02: eprom strap low: mode from link strap and select pin input.
// RULE_03: system ties link boot strap low permanently.
// RULE_04: eprom mode drives boot memory select as eprom chip select.
// RULE_05: only current bus master drives boot memory select output; code keeps the old drive over edges with clk_en low.
// RULE_06: select pin low as input means no boot, run external memory.
// RULE_07: pin is driven only in eprom mode; three-stated otherwise, never otherwise driven.
// RULE_08: system hard-wires eprom strap and select pin level.
// RULE_09: straps 0,0 with select pin high selects host boot.
// RULE_10: straps sampled during reset; mode held until next reset.
module bmsel_top
   import bmsel_pkg::*;
(
   // clock, reset, enable
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // strap pins, including select pin level as input
   input  wire logic       eprom_boot_strap,
   input  wire logic       link_boot_strap,
   input  wire logic       boot_memory_select_i,
   // core side
   input  wire logic       bus_master,
   input  wire logic       boot_cs_req,
   // boot memory select pin drive
   output logic            boot_memory_select_o,
   output logic            boot_memory_select_oe,
   // decoded mode
   output bmsel_mode_type  boot_mode,
   output logic            mode_valid
);
`include "bmsel_map.svh"

   bmsel_straps_type straps_sync;
   bmsel_mode_type   next_boot_mode;
   logic             next_mode_valid;
   bmsel_pin_type    pin;
   bmsel_pin_type    next_pin;
   logic             rst_seen;
   logic             next_rst_seen;
   bmsel_mode_type   decoded;

   // pins come from outside the clock domain; the synchroniser is left
   // unreset so that strap levels keep flowing through while reset is held
   bmsel_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_b   (1'b1),
      .clk_en  (clk_en),
      .din     ({eprom_boot_strap, link_boot_strap, boot_memory_select_i}),
      .dout    (straps_sync)
   );

   // strap decode; eprom strap dominates
   always_comb begin
      if (straps_sync.eprom_boot_strap) begin
         decoded = bmsel_mode_eprom_type_e;                 // see RULE_01
      end else if (straps_sync.link_boot_strap) begin
         decoded = bmsel_mode_illegal_type_e;               // see RULE_03
      end else if (straps_sync.boot_memory_select) begin
         decoded = bmsel_mode_host_type_e;                  // see RULE_02 see RULE_09
      end else begin
         decoded = bmsel_mode_none_type_e;                  // see RULE_06
      end
   end

   // mode follows straps while reset is held, then freezes
   always_comb begin
      next_rst_seen   = rst_seen;
      next_boot_mode  = boot_mode;
      next_mode_valid = mode_valid;
      if (!rst_b) begin
         next_rst_seen   = 1'b1;
         next_boot_mode  = decoded;                         // see RULE_10
         next_mode_valid = 1'b0;
      end else if (rst_seen) begin
         next_rst_seen   = 1'b0;
         next_mode_valid = 1'b1;                            // see RULE_10
      end
   end

   // pin drive: only eprom mode ever enables the driver; slaves float it after the next enabled edge
   always_comb begin
      next_pin.boot_memory_select_o  = `BMSEL_CS_IDLE;
      next_pin.boot_memory_select_oe = 1'b0;
      if (rst_b && mode_valid && boot_mode == bmsel_mode_eprom_type_e
          && bus_master) begin
         next_pin.boot_memory_select_oe = 1'b1;             // see RULE_04 see RULE_05 see RULE_07
         next_pin.boot_memory_select_o  = ~boot_cs_req;     // active low chip select
      end
   end

   // the mode register is captured, not reset to a constant, during reset
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         rst_seen   <= next_rst_seen;
         boot_mode  <= next_boot_mode;
         mode_valid <= next_mode_valid;
         pin        <= next_pin;
      end
   end

   // the pin pair leaves straight from the pin register, no logic after it
   assign boot_memory_select_o  = pin.boot_memory_select_o;
   assign boot_memory_select_oe = pin.boot_memory_select_oe;

   // helper: cycles since the mode froze; saturates so long runs never wrap
   logic [3:0] valid_cnt;
   logic [3:0] next_valid_cnt;

   always_comb begin
      next_valid_cnt = valid_cnt;
      if (!rst_b) begin
         next_valid_cnt = 4'h0;
      end else if (mode_valid && valid_cnt != 4'hf) begin
         next_valid_cnt = valid_cnt + 4'h1;
      end
   end

   // reset waits for an enabled edge here too, so a frozen block keeps its count
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         valid_cnt <= next_valid_cnt;
      end
   end

   // decode timing and the checks below assume exactly two strap flops
   if (`BMSEL_SYNC_STAGES != 2) begin : g_stage_check
      $error("bmsel_top expects a two-stage strap synchroniser");
   end

   // pin drive: bus master in eprom mode only; an edge with clk_en low keeps old drive
   a_oe_needs_master: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_05
      boot_memory_select_oe && $past(clk_en)
      |-> $past(bus_master) && boot_mode == bmsel_mode_eprom_type_e)
      else $error("select pin driven without bus mastership in eprom mode");

   a_slave_floats: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_05
      clk_en && !bus_master
      |=> !boot_memory_select_oe)
      else $error("select pin still driven after bus mastership was lost");

   a_oe_only_eprom: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_07
      boot_mode != bmsel_mode_eprom_type_e
      |-> !boot_memory_select_oe)
      else $error("select pin driven outside eprom mode");

   a_eprom_drive: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_04
      clk_en && mode_valid && boot_mode == bmsel_mode_eprom_type_e && bus_master
      |=> boot_memory_select_oe && (boot_memory_select_o == !$past(boot_cs_req)))
      else $error("eprom chip select not driven");

   a_cs_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_04
      !boot_memory_select_oe
      |-> boot_memory_select_o)
      else $error("chip select value not idle while the driver is off");

   // reset: driver off and valid low; release gives a frozen, valid mode
   a_reset_idle: assert property (@(posedge sys_clk) // see RULE_07
      clk_en && !rst_b
      |=> !boot_memory_select_oe && boot_memory_select_o)
      else $error("select pin not released during reset");

   a_valid_low: assert property (@(posedge sys_clk) // see RULE_10
      clk_en && !rst_b
      |=> !mode_valid)
      else $error("mode marked valid during reset");

   a_valid_rises: assert property (@(posedge sys_clk) // see RULE_10
      clk_en && !rst_b ##1 clk_en && rst_b ##1 clk_en
      |=> mode_valid)
      else $error("mode not valid after reset release");

   a_valid_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_10
      mode_valid
      |=> mode_valid)
      else $error("mode valid dropped outside reset");

   a_mode_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE_10
      mode_valid
      |=> $stable(boot_mode))
      else $error("boot mode changed outside reset");

   a_enable_freeze: assert property (@(posedge sys_clk) // see RULE_10
      !clk_en
      |=> $stable(boot_mode) && $stable(mode_valid)
          && $stable(boot_memory_select_oe) && $stable(boot_memory_select_o))
      else $error("state moved while the clock enable was low");

   // decode as captured during reset; eprom strap dominates
   a_eprom_wins: assert property (@(posedge sys_clk) // see RULE_01
      clk_en && !rst_b && straps_sync.eprom_boot_strap
      |=> boot_mode == bmsel_mode_eprom_type_e)
      else $error("eprom strap did not select eprom boot");

   a_host_mode: assert property (@(posedge sys_clk) // see RULE_09
      clk_en && !rst_b && straps_sync == 3'h1
      |=> boot_mode == bmsel_mode_host_type_e)
      else $error("host boot not decoded");

   a_no_boot: assert property (@(posedge sys_clk) // see RULE_06
      clk_en && !rst_b && straps_sync == 3'h0
      |=> boot_mode == bmsel_mode_none_type_e)
      else $error("no-boot not decoded");

   a_link_strap: assert property (@(posedge sys_clk) // see RULE_02
      clk_en && !rst_b && straps_sync == 3'h2
      |=> boot_mode == bmsel_mode_illegal_type_e)
      else $error("link strap high not flagged");

   // main scenarios: chip select, host, no boot, slave, long hold
   c_eprom: cover property (@(posedge sys_clk)
      boot_memory_select_oe && !boot_memory_select_o);
   c_host:  cover property (@(posedge sys_clk)
      mode_valid && boot_mode == bmsel_mode_host_type_e);
   c_none:  cover property (@(posedge sys_clk)
      mode_valid && boot_mode == bmsel_mode_none_type_e);
   c_slave: cover property (@(posedge sys_clk)
      mode_valid && boot_mode == bmsel_mode_eprom_type_e && !bus_master ##1 !boot_memory_select_oe);
   c_long:  cover property (@(posedge sys_clk)
      valid_cnt == 4'hf);
endmodule

// File: bmsel_board_model.sv
// board model: hard-wired straps and the boot memory select wire
module bmsel_board_model
   import bmsel_pkg::*;
(
   // wiring chosen by the bench
   input  wire bmsel_straps_type wiring,
   // pin drive from the device
   input  wire bmsel_pin_type    pin,
   // levels seen by the device
   output logic                  eprom_boot_strap,
   output logic                  link_boot_strap,
   output logic                  boot_memory_select_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // straps are fixed wiring, link strap low unless a fault is staged
   assign eprom_boot_strap = wiring.eprom_boot_strap;
   assign link_boot_strap  = wiring.link_boot_strap;
   // device drive wins, else the hard-wired level shows
   assign boot_memory_select_i = pin.boot_memory_select_oe ?
      pin.boot_memory_select_o : wiring.boot_memory_select;
endmodule

// File: bmsel_top_tb_top.sv
// self-checking bench for the boot mode select block
module bmsel_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bmsel_pkg::*;
   logic             sys_clk, rst_b, clk_en, bus_master, boot_cs_req;
   logic             e, l, b, pin_o, pin_oe, valid;
   bmsel_mode_type   mode;
   bmsel_straps_type w;
   int               miscompares, cmp_count;

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   bmsel_board_model u_bmsel_board_model (.wiring(w), .pin({pin_o, pin_oe}),
      .eprom_boot_strap(e), .link_boot_strap(l), .boot_memory_select_i(b));
   bmsel_top u_bmsel_top (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
      .eprom_boot_strap(e), .link_boot_strap(l), .boot_memory_select_i(b),
      .bus_master(bus_master), .boot_cs_req(boot_cs_req),
      .boot_memory_select_o(pin_o), .boot_memory_select_oe(pin_oe),
      .boot_mode(mode), .mode_valid(valid));

   task check(input logic [1:0] seen, input logic [1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // inputs move on falling edges only
   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // reset 10 cycles, mode frozen and valid one edge after release, checked after two
   task boot(input bmsel_straps_type s, input bmsel_mode_type m);
      w = s;
      rst_b = 1'b0;
      tick(10);
      rst_b = 1'b1;
      tick(2);
      check({1'b0, valid}, 2'h1);
      check(mode, m);
      check({1'b0, pin_oe}, 2'h0);
   endtask
   task test_decode;
      boot(3'h4, bmsel_mode_eprom_type_e);
      boot(3'h5, bmsel_mode_eprom_type_e);
      boot(3'h1, bmsel_mode_host_type_e);
      boot(3'h0, bmsel_mode_none_type_e);
      boot(3'h3, bmsel_mode_illegal_type_e);
   endtask
   // strap changes after reset must not reach the mode
   task test_hold;
      boot(3'h4, bmsel_mode_eprom_type_e);
      w = 3'h1;
      tick(4);
      check(mode, bmsel_mode_eprom_type_e);
   endtask
   // chip select follows request one edge late, only as master
   task test_eprom_cs;
      boot(3'h5, bmsel_mode_eprom_type_e);
      bus_master = 1'b1;
      boot_cs_req = 1'b1;
      tick(1);
      check({pin_oe, pin_o}, 2'h2);
      boot_cs_req = 1'b0;
      tick(1);
      check({pin_oe, pin_o}, 2'h3);
      // frozen edges keep the old drive although mastership is gone
      clk_en = 1'b0;
      bus_master = 1'b0;
      tick(2);
      check({pin_oe, pin_o}, 2'h3);
      clk_en = 1'b1;
      tick(1);
      check({pin_oe, pin_o}, 2'h1);
   endtask
   // outside eprom mode the pin is never driven
   task test_no_drive;
      boot(3'h1, bmsel_mode_host_type_e);
      bus_master = 1'b1;
      boot_cs_req = 1'b1;
      tick(2);
      check({1'b0, pin_oe}, 2'h0);
      bus_master = 1'b0;
      boot_cs_req = 1'b0;
   endtask

   // watchdog well past the 108 cycles the tests need
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      bus_master = 1'b0;
      boot_cs_req = 1'b0;
      w = 3'h0;
      // first scenario starts on a falling edge, not at time zero
      tick(1);
      test_decode();
      test_hold();
      test_eprom_cs();
      test_no_drive();
      print_verdict();
   end
endmodule
